/* File: rtl/rtc_alarm_irq.sv */
// alarm, interrupt and wakeup logic of the real-time clock
// assumes rtc_tick pulses once per rtc clock and all inputs are synchronous to clk;
// rst_n is the clock's own power-on reset, the chip reset does not reach here
//
// What this block does
// RULE1 - millisecond alarm is 1+4+4+4 bit bcd; above 1023 never matches
// RULE2 - seconds and minutes alarms are 3+4 bit bcd; beyond 59 never matches
// RULE3 - hours alarm is 2+4 bit bcd; outside 1 to 23 never matches
// RULE4 - day alarm is 2+4 bit bcd; outside 1 to 31 never matches
// RULE5 - month alarm is 1+4 bit bcd; outside 1 to 12 never matches
// RULE6 - year alarm is two 4-bit bcd digits; beyond 99 never matches
// RULE7 - alarm writes are buffered, load request copies all within one rtc clock
// RULE8 - alarm registers always readable, never changed by the clock
// RULE9 - periodic, alarm and wake sources share one cpu interrupt line
// RULE10 - enable bit 0 gates the cpu interrupt; source register picks events
// RULE11 - any flag, the alarm event or the wake pin as input drives the master clock wakeup request
// RULE12 - host sets wake pin direction to zero to use the wake interrupt
// RULE13 - enabled events set flags; writing one clears, zero keeps
// RULE14 - interrupt is a level, high while enabled and any flag is set
// RULE15 - lost-power flag tells software to reset the clock
// RULE16 - bus sync takes 3 rtc clocks; no valid reads before that
// RULE17 - source bits 0 to 4 enable millisecond to day periodic events
// RULE18 - periodic event fires on each unit increment and sets a sticky flag
// RULE19 - alarm fires on equal time; source bit 15 enables, flag bit 15 records
// RULE20 - soft reset bit returns every register but the lost-power flag to its default; that flag it clears
// RULE21 - only own power-on reset and soft reset reset this block
// RULE22 - host waits three rtc clocks after soft reset before access
// RULE23 - millisecond counter counts 0 to 1023 bcd every 32 rtc clocks
// RULE24 - rising wake pin with enables raises interrupt; clocks-on follows level
// RULE25 - alarm compared once per millisecond tick, after the counters move
`include "rtc_alarm_params.svh"
`default_nettype none
module rtc_alarm_irq (
  // clock and own power-on reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port, cpu word addresses
  input  wire logic [15:0] addr,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [15:0] wdata,
  output logic [15:0]      rdata,
  output logic             sync_ready,
  // rtc clock pulse
  input  wire logic        rtc_tick,
  // running calendar fields and their increment pulses
  input  wire logic [6:0]  cur_sec,
  input  wire logic [6:0]  cur_min,
  input  wire logic [5:0]  cur_hour,
  input  wire logic [5:0]  cur_day,
  input  wire logic [4:0]  cur_month,
  input  wire logic [7:0]  cur_year,
  input  wire logic        min_inc,
  input  wire logic        hour_inc,
  input  wire logic        day_inc,
  // millisecond count to the calendar
  output logic [12:0]      ms_value,
  output logic             sec_advance,
  // wake pin input side
  input  wire logic        wake_pin_in,
  // to cpu and clock gate
  output logic             irq,
  output logic             clk_wake_req
);

  typedef struct packed {
    rtc_alarm_pkg::sync_t      sync;
    logic [1:0]                sync_cnt;
    logic                      irq_en;
    logic                      load_pend;
    rtc_alarm_pkg::alarm_set_t buf_set;
    rtc_alarm_pkg::alarm_set_t act_set;
    logic [15:0]               src_en;
    logic [15:0]               flags;
    logic                      pwr_lost;
    logic                      wake_dir;
    logic                      wake_prev;
    logic                      cmp_pend;
    logic [15:0]               rdata;
  } top_state_t;

  top_state_t                s_r;
  top_state_t                s_nxt;
  logic                      ms_tick;
  logic                      match;
  logic                      soft_reset;
  logic                      wr_ok;
  logic                      alarm_event;
  logic [15:0]               events;
  rtc_alarm_pkg::alarm_set_t now;

  // zero-extend a field to a bus word
  function automatic logic [15:0] ext16(input logic [12:0] v);
    ext16 = {3'b000, v};
  endfunction : ext16

  // accesses only count once the bus sync has settled
  assign wr_ok      = wr_en && (s_r.sync == rtc_alarm_pkg::SYNC_RUN);
  // RULE20 soft reset strobe
  assign soft_reset = wr_ok && (addr == `RTC_ADDR_OSC) && wdata[`RTC_OSC_RESET_BIT];

  rtc_ms_counter u_ms (
    .clk         (clk),
    .rst_n       (rst_n),
    .rtc_tick    (rtc_tick),
    .clear       (soft_reset),
    .ms_value    (ms_value),
    .ms_tick     (ms_tick),
    .sec_advance (sec_advance)
  );

  // running time as one alarm-shaped set
  assign now = '{year: cur_year, month: cur_month, day: cur_day, hour: cur_hour,
                 min: cur_min, sec: cur_sec, ms: ms_value};

  rtc_alarm_match u_match (
    .clk   (clk),
    .rst_n (rst_n),
    .alarm (s_r.act_set),
    .now   (now),
    .match (match)
  );

  // RULE25 one look per millisecond tick
  assign alarm_event = s_r.cmp_pend && match;

  // raw events before source enables
  always_comb
  begin
    events = 16'h0000;
    // RULE18 periodic unit increments
    events[`RTC_SRC_MS_BIT]   = ms_tick;
    events[`RTC_SRC_SEC_BIT]  = sec_advance;
    events[`RTC_SRC_MIN_BIT]  = min_inc;
    events[`RTC_SRC_HOUR_BIT] = hour_inc;
    events[`RTC_SRC_DAY_BIT]  = day_inc;
    // RULE24 rising wake pin while it is an input
    events[`RTC_SRC_EXT_BIT]  = !s_r.wake_dir && wake_pin_in && !s_r.wake_prev;
    // RULE19 alarm event
    events[`RTC_SRC_ALARM_BIT] = alarm_event;
  end

  // next state: sync, register writes, flags, reads
  always_comb
  begin
    logic [15:0] clr;
    clr   = 16'h0000;
    s_nxt = s_r;
    s_nxt.wake_prev = wake_pin_in;
    s_nxt.cmp_pend  = ms_tick;
    s_nxt.rdata     = 16'h0000;
    // RULE16 three rtc clocks before the bus is trusted
    case (s_r.sync)
      rtc_alarm_pkg::SYNC_WAIT:
      begin
        if (rtc_tick)
          s_nxt.sync_cnt = s_r.sync_cnt + 2'd1;
        if (rtc_tick && (s_r.sync_cnt + 2'd1 == `RTC_SYNC_TICKS))
          s_nxt.sync = rtc_alarm_pkg::SYNC_RUN;
      end
      rtc_alarm_pkg::SYNC_RUN:
        s_nxt.sync = rtc_alarm_pkg::SYNC_RUN;
      default:
        s_nxt.sync = rtc_alarm_pkg::SYNC_WAIT;
    endcase
    // RULE7 copy all buffered fields on the next rtc clock
    if (s_r.load_pend && rtc_tick)
    begin
      s_nxt.act_set   = s_r.buf_set;
      s_nxt.load_pend = 1'b0;
    end
    if (wr_ok)
    begin
      case (addr)
        // RULE10 top-level enable
        `RTC_ADDR_IRQ_EN:    s_nxt.irq_en = wdata[`RTC_IRQ_EN_BIT];
        `RTC_ADDR_UPDATE:    s_nxt.load_pend = s_r.load_pend | wdata[`RTC_ALM_LOAD_BIT];
        `RTC_ADDR_ALM_MS:    s_nxt.buf_set.ms = wdata[12:0];
        `RTC_ADDR_ALM_SEC:   s_nxt.buf_set.sec = wdata[6:0];
        `RTC_ADDR_ALM_MIN:   s_nxt.buf_set.min = wdata[6:0];
        `RTC_ADDR_ALM_HOUR:  s_nxt.buf_set.hour = wdata[5:0];
        `RTC_ADDR_ALM_DAY:   s_nxt.buf_set.day = wdata[5:0];
        `RTC_ADDR_ALM_MONTH: s_nxt.buf_set.month = wdata[4:0];
        `RTC_ADDR_ALM_YEAR:  s_nxt.buf_set.year = wdata[7:0];
        // RULE13 write one to clear
        `RTC_ADDR_FLAGS:     clr = wdata;
        // RULE17 periodic and other source enables
        `RTC_ADDR_SRC_EN:    s_nxt.src_en = wdata;
        `RTC_ADDR_PWR_CTRL:  s_nxt.wake_dir = wdata[`RTC_WAKE_DIR_BIT];
        default:             clr = 16'h0000;
      endcase
    end
    // RULE13 enabled events set flags, set beats clear
    s_nxt.flags = (s_r.flags & ~clr) | (events & s_r.src_en);
    // RULE8 reads show the buffered alarm, never clock-modified
    if (rd_en && s_r.sync == rtc_alarm_pkg::SYNC_RUN)
    begin
      case (addr)
        `RTC_ADDR_IRQ_EN:    s_nxt.rdata = {15'h0000, s_r.irq_en};
        `RTC_ADDR_UPDATE:    s_nxt.rdata = {1'b0, s_r.load_pend, 14'h0000};
        `RTC_ADDR_ALM_MS:    s_nxt.rdata = ext16(s_r.buf_set.ms);
        `RTC_ADDR_ALM_SEC:   s_nxt.rdata = ext16({6'h00, s_r.buf_set.sec});
        `RTC_ADDR_ALM_MIN:   s_nxt.rdata = ext16({6'h00, s_r.buf_set.min});
        `RTC_ADDR_ALM_HOUR:  s_nxt.rdata = ext16({7'h00, s_r.buf_set.hour});
        `RTC_ADDR_ALM_DAY:   s_nxt.rdata = ext16({7'h00, s_r.buf_set.day});
        `RTC_ADDR_ALM_MONTH: s_nxt.rdata = ext16({8'h00, s_r.buf_set.month});
        `RTC_ADDR_ALM_YEAR:  s_nxt.rdata = ext16({5'h00, s_r.buf_set.year});
        `RTC_ADDR_FLAGS:     s_nxt.rdata = s_r.flags;
        // RULE15 lost-power status
        `RTC_ADDR_PWR_LOST:  s_nxt.rdata = {15'h0000, s_r.pwr_lost};
        `RTC_ADDR_SRC_EN:    s_nxt.rdata = s_r.src_en;
        `RTC_ADDR_PWR_CTRL:
          s_nxt.rdata = 16'(s_r.wake_dir) << `RTC_WAKE_DIR_BIT;
        default:             s_nxt.rdata = 16'h0000;
      endcase
    end
    // RULE20 soft reset: defaults everywhere, power flag cleared, resync
    if (soft_reset)
    begin
      s_nxt          = '0;
      s_nxt.sync     = rtc_alarm_pkg::SYNC_WAIT;
      s_nxt.act_set  = `RTC_ALARM_RST;
      s_nxt.buf_set  = `RTC_ALARM_RST;
      s_nxt.src_en   = `RTC_SRC_EN_RST;
      s_nxt.wake_dir = `RTC_WAKE_DIR_RST;
      s_nxt.pwr_lost = 1'b0;
    end
  end

  // RULE21 only the own power-on reset acts asynchronously
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r          <= '0;
      s_r.sync     <= rtc_alarm_pkg::SYNC_WAIT;
      s_r.buf_set  <= `RTC_ALARM_RST;
      s_r.act_set  <= `RTC_ALARM_RST;
      s_r.src_en   <= `RTC_SRC_EN_RST;
      s_r.wake_dir <= `RTC_WAKE_DIR_RST;
      s_r.pwr_lost <= `RTC_PWR_LOST_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // RULE9 one line; RULE14 level while enabled and any flag stands
  assign irq          = s_r.irq_en && (s_r.flags != 16'h0000);
  // RULE11 alarm event, flags or high wake input release the clock gate
  assign clk_wake_req = (s_r.flags != 16'h0000) || alarm_event
    || (!s_r.wake_dir && wake_pin_in);
  assign rdata        = s_r.rdata;
  assign sync_ready   = (s_r.sync == rtc_alarm_pkg::SYNC_RUN);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // RULE7 load copies the whole set on one rtc clock
  a_load_copies_all: assert property (s_r.load_pend && rtc_tick && !soft_reset
    |=> s_r.act_set == $past(s_r.buf_set) && !s_r.load_pend) // RULE7
    else $error("alarm load did not copy the buffer");
  // RULE8 active alarm moves only on a load or a soft reset
  a_active_stable: assert property (!(s_r.load_pend && rtc_tick) && !soft_reset
    |=> $stable(s_r.act_set)) // RULE8
    else $error("active alarm changed without a load");
  // RULE19 enabled alarm sets flag 15; the line then follows irq_en
  a_alarm_flag_set: assert property (alarm_event && s_r.src_en[`RTC_SRC_ALARM_BIT]
    && !soft_reset |=> s_r.flags[`RTC_SRC_ALARM_BIT] ##0 (irq == s_r.irq_en)) // RULE19
    else $error("alarm did not set its flag");
  // RULE13 flag stands until a written one or a soft reset
  a_flag_sticky: assert property (s_r.flags[`RTC_SRC_ALARM_BIT] && !soft_reset
    && !(wr_ok && addr == `RTC_ADDR_FLAGS && wdata[`RTC_SRC_ALARM_BIT])
    |=> s_r.flags[`RTC_SRC_ALARM_BIT]) // RULE13
    else $error("flag dropped without a clear");
  // RULE13 a written one clears when no new event
  a_flag_clears: assert property (wr_ok && addr == `RTC_ADDR_FLAGS && wdata[`RTC_SRC_MS_BIT]
    && !ms_tick |=> !s_r.flags[`RTC_SRC_MS_BIT]) // RULE13
    else $error("write one did not clear the flag");
  // RULE14 the line holds across cycles while flags stand
  a_irq_level: assert property (irq && !wr_ok |=> irq) // RULE14
    else $error("interrupt dropped with flags still set");
  // RULE11 flags turning nonzero find the clock wakeup asserted in that cycle
  a_wake_from_flag: assert property ($rose(s_r.flags != 16'h0000) |-> clk_wake_req) // RULE11
    else $error("flag set without clock wakeup");
  // RULE16 reads answer zero until three rtc clocks passed
  a_sync_hides_reads: assert property (!sync_ready |=> rdata == 16'h0000) // RULE16
    else $error("read data before bus sync");
  // RULE20 soft reset clears flags and the line
  a_soft_reset_clears: assert property (soft_reset |=> s_r.flags == 16'h0000 && !irq
    && !sync_ready) // RULE20
    else $error("soft reset left state behind");
  // RULE24 rising wake edge with enable sets its flag
  a_wake_edge_flag: assert property (events[`RTC_SRC_EXT_BIT] && s_r.src_en[`RTC_SRC_EXT_BIT]
    && !soft_reset |=> s_r.flags[`RTC_SRC_EXT_BIT]) // RULE24
    else $error("wake edge lost");

  c_alarm_irq: cover property (alarm_event ##1 irq);
  c_wake_edge: cover property (events[`RTC_SRC_EXT_BIT] ##1 irq);
  c_load_then_match: cover property (s_r.load_pend && rtc_tick ##[1:1000] alarm_event);
  c_soft_reset: cover property (soft_reset ##1 !sync_ready);

endmodule : rtc_alarm_irq
`default_nettype wire

/* File: rtl/rtc_alarm_match.sv */
// compares the active alarm set with the running time, registered
// assumes time fields are stable bcd from the calendar
`include "rtc_alarm_params.svh"
`default_nettype none
module rtc_alarm_match (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // operands
  input  wire rtc_alarm_pkg::alarm_set_t alarm,
  input  wire rtc_alarm_pkg::alarm_set_t now,
  // result
  output logic                           match
);

  typedef struct packed {
    logic match;
  } match_state_t;

  match_state_t s_r;
  match_state_t s_nxt;
  logic         ms_ok;
  logic         sec_ok;
  logic         min_ok;
  logic         hour_ok;
  logic         day_ok;
  logic         mon_ok;
  logic         year_ok;

  // digit 0 to 9
  function automatic logic dig_ok(input logic [3:0] d);
    dig_ok = (d <= 4'h9);
  endfunction : dig_ok

  // range checks: an illegal setting can never match
  always_comb
  begin
    // RULE1 up to 1023
    ms_ok = dig_ok(alarm.ms[11:8]) && dig_ok(alarm.ms[7:4]) && dig_ok(alarm.ms[3:0])
      && (!alarm.ms[12] || (alarm.ms[11:0] <= 12'h023));
    // RULE2 up to 59
    sec_ok  = (alarm.sec[6:4] <= 3'h5) && dig_ok(alarm.sec[3:0]);
    min_ok  = (alarm.min[6:4] <= 3'h5) && dig_ok(alarm.min[3:0]);
    // RULE3 1 to 23
    hour_ok = dig_ok(alarm.hour[3:0]) && (alarm.hour <= 6'h23) && (alarm.hour != 6'h00);
    // RULE4 1 to 31
    day_ok  = dig_ok(alarm.day[3:0]) && (alarm.day <= 6'h31) && (alarm.day != 6'h00);
    // RULE5 1 to 12
    mon_ok  = dig_ok(alarm.month[3:0]) && (alarm.month <= 5'h12) && (alarm.month != 5'h00);
    // RULE6 0 to 99
    year_ok = dig_ok(alarm.year[7:4]) && dig_ok(alarm.year[3:0]);
    s_nxt.match = ms_ok && sec_ok && min_ok && hour_ok && day_ok && mon_ok && year_ok
      && (alarm == now);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign match = s_r.match;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // RULE1 bad milliseconds never match
  a_ms_range_guard: assert property (!ms_ok |=> !match) // RULE1
    else $error("out of range millisecond alarm matched");
  // RULE3 hour zero or above 23 never matches
  a_hour_range_guard: assert property (!hour_ok || !day_ok || !mon_ok |=> !match) // RULE3
    else $error("out of range hour, day or month alarm matched");
  // RULE6 equal legal fields match next cycle
  a_equal_matches: assert property (ms_ok && sec_ok && min_ok && hour_ok && day_ok && mon_ok
    && year_ok && alarm == now |=> match) // RULE6
    else $error("legal equal alarm did not match");

endmodule : rtc_alarm_match
`default_nettype wire

/* File: rtl/rtc_alarm_params.svh */
// constants of the clock's alarm and interrupt block: word addresses,
// bit positions, reset values and counts; included by every design module file and the bench
`ifndef RTC_ALARM_PARAMS_SVH
`define RTC_ALARM_PARAMS_SVH

// cpu word addresses
`define RTC_ADDR_IRQ_EN    16'h1900
`define RTC_ADDR_UPDATE    16'h1901
`define RTC_ADDR_ALM_MS    16'h1905
`define RTC_ADDR_ALM_SEC   16'h1909
`define RTC_ADDR_ALM_MIN   16'h190D
`define RTC_ADDR_ALM_HOUR  16'h1911
`define RTC_ADDR_ALM_DAY   16'h1915
`define RTC_ADDR_ALM_MONTH 16'h1919
`define RTC_ADDR_ALM_YEAR  16'h191D
`define RTC_ADDR_FLAGS     16'h1920
`define RTC_ADDR_PWR_LOST  16'h1921
`define RTC_ADDR_SRC_EN    16'h1924
`define RTC_ADDR_OSC       16'h192C
`define RTC_ADDR_PWR_CTRL  16'h1930

// bit positions
`define RTC_IRQ_EN_BIT     0
`define RTC_ALM_LOAD_BIT   14
`define RTC_SRC_MS_BIT     0
`define RTC_SRC_SEC_BIT    1
`define RTC_SRC_MIN_BIT    2
`define RTC_SRC_HOUR_BIT   3
`define RTC_SRC_DAY_BIT    4
`define RTC_SRC_EXT_BIT    5
`define RTC_SRC_ALARM_BIT  15
`define RTC_OSC_RESET_BIT  5
`define RTC_WAKE_DIR_BIT   2

// reset values
`define RTC_PWR_LOST_RST   1'b1
`define RTC_WAKE_DIR_RST   1'b0
`define RTC_ALARM_RST      52'h0_0000_0000_0000
`define RTC_SRC_EN_RST     16'h0000

// counts: last prescale value and sync length in rtc clocks, last bcd millisecond value
`define RTC_TICKS_PER_MS   5'd31
`define RTC_SYNC_TICKS     2'd3
`define RTC_MS_LAST        13'h1023

`endif

/* File: rtl/rtc_alarm_pkg.sv */
// types shared by the alarm and interrupt block of the clock
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package rtc_alarm_pkg;

  // one set of bcd alarm fields, milliseconds down at the low end
  typedef struct packed {
    logic [7:0]  year;
    logic [4:0]  month;
    logic [5:0]  day;
    logic [5:0]  hour;
    logic [6:0]  min;
    logic [6:0]  sec;
    logic [12:0] ms;
  } alarm_set_t;

  // bus sync state after any reset
  typedef enum logic [1:0] {
    SYNC_WAIT = 2'b01,
    SYNC_RUN  = 2'b10
  } sync_t;

endpackage : rtc_alarm_pkg
`default_nettype wire

/* File: rtl/rtc_ms_counter.sv */
// bcd millisecond counter, 32 rtc clocks per count, 0 to 1023
// assumes rtc_tick is a one-cycle pulse per rtc clock, synchronous to clk
`include "rtc_alarm_params.svh"
`default_nettype none
module rtc_ms_counter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        rtc_tick,
  input  wire logic        clear,
  // results
  output logic [12:0]      ms_value,
  output logic             ms_tick,
  output logic             sec_advance
);

  typedef struct packed {
    logic [4:0]  pre;
    logic [12:0] ms;
    logic        tick;
    logic        wrap;
  } ms_state_t;

  ms_state_t s_r;
  ms_state_t s_nxt;

  // one bcd digit plus one, carry on top
  function automatic logic [4:0] dig_inc(input logic [3:0] d);
    dig_inc = (d == 4'h9) ? 5'h10 : {1'b0, d + 4'h1};
  endfunction : dig_inc

  // prescale and bcd count
  always_comb
  begin
    logic [4:0] d0;
    logic [4:0] d1;
    logic [4:0] d2;
    d0 = dig_inc(s_r.ms[3:0]);
    d1 = d0[4] ? dig_inc(s_r.ms[7:4]) : {1'b0, s_r.ms[7:4]};
    d2 = d1[4] ? dig_inc(s_r.ms[11:8]) : {1'b0, s_r.ms[11:8]};
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.wrap = 1'b0;
    if (clear)
    begin
      s_nxt = '0;
    end
    else if (rtc_tick)
    begin
      // RULE23 count every 32
      if (s_r.pre == `RTC_TICKS_PER_MS)
      begin
        s_nxt.pre  = 5'd0;
        s_nxt.tick = 1'b1;
        if (s_r.ms == `RTC_MS_LAST)
        begin
          s_nxt.ms   = 13'h0000;
          s_nxt.wrap = 1'b1;
        end
        else
        begin
          s_nxt.ms = {s_r.ms[12] | d2[4], d2[3:0], d1[3:0], d0[3:0]};
        end
      end
      else
      begin
        s_nxt.pre = s_r.pre + 5'd1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ms_value    = s_r.ms;
  assign ms_tick     = s_r.tick;
  assign sec_advance = s_r.wrap;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // RULE23 wrap lands on zero
  a_ms_wrap_zero: assert property (sec_advance |-> ms_tick && ms_value == 13'h0000) // RULE23
    else $error("seconds advanced without millisecond wrap");
  // RULE23 tick follows prescale end
  a_ms_tick_spacing: assert property (ms_tick |-> s_r.pre == 5'd0 && $past(rtc_tick)) // RULE23
    else $error("millisecond tick off prescale");
  c_ms_wrap: cover property (sec_advance);

endmodule : rtc_ms_counter
`default_nettype wire

/* File: tb/rtc_tick_src.sv */
// rtc clock model: one-cycle tick every fourth cpu clock
// assumes clk is the 10 MHz cpu clock, more than 3x the rtc rate
`default_nettype none
module rtc_tick_src (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // rtc clock pulse
  output logic      tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_r;
  // free-running divider, the oscillator never pauses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  end
  assign tick = (cnt_r == 2'h3);
endmodule : rtc_tick_src
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench: register tasks and a scenario sequence
// assumes the design files and rtc_tick_src are compiled first
`include "rtc_alarm_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus with time-zero values
  logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic        wake = 1'b0, mi = 1'b0, hi = 1'b0, di = 1'b0, tick;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic [7:0]  sec = 8'h00, mn = 8'h00, hr = 8'h01, dy = 8'h01, mo = 8'h01, yr = 8'h00;
  logic [12:0] ms_value;
  logic        sync_ready, sec_advance, irq, clk_wake_req;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          ms_gap = 0;
  // calendars with one field out of range, alarm set to the same value
  logic [47:0] bad [9] = '{48'h6019_0307_0510, 48'h4660_0307_0510, 48'h4619_0007_0510,
    48'h4619_2407_0510, 48'h4619_0332_0510, 48'h4619_0300_0510, 48'h4619_0307_1310,
    48'h4619_0307_0010, 48'h4619_0307_059A};

  rtc_alarm_irq uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .sync_ready(sync_ready), .rtc_tick(tick),
    .cur_sec(sec[6:0]), .cur_min(mn[6:0]), .cur_hour(hr[5:0]), .cur_day(dy[5:0]),
    .cur_month(mo[4:0]), .cur_year(yr), .min_inc(mi), .hour_inc(hi), .day_inc(di),
    .ms_value(ms_value), .sec_advance(sec_advance), .wake_pin_in(wake), .irq(irq),
    .clk_wake_req(clk_wake_req));
  rtc_tick_src osc (.clk(clk), .rst_n(rst_n), .tick(tick));

  // 10 MHz clock
  initial
  begin
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // write strobe held across one rising edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr

  // read data stands the cycle after the read edge
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    chk(what, exp, rdata);
  endtask : rd

  // set calendar and alarm fields alike; ms alarm two counts ahead
  task automatic arm(input logic [47:0] t, input logic ld);
    @(negedge clk);
    {sec, mn, hr, dy, mo, yr} = t;
    repeat (1300) if (ms_value[3:0] !== 4'h0) @(negedge clk);
    wr(`RTC_ADDR_ALM_MS, {3'h0, ms_value[12:4], 4'h2});
    wr(`RTC_ADDR_ALM_SEC, {8'h00, t[47:40]});
    wr(`RTC_ADDR_ALM_MIN, {8'h00, t[39:32]});
    wr(`RTC_ADDR_ALM_HOUR, {8'h00, t[31:24]});
    wr(`RTC_ADDR_ALM_DAY, {8'h00, t[23:16]});
    wr(`RTC_ADDR_ALM_MONTH, {8'h00, t[15:8]});
    wr(`RTC_ADDR_ALM_YEAR, {8'h00, t[7:0]});
    if (ld)
      wr(`RTC_ADDR_UPDATE, 16'h4000);
  endtask : arm

  // scenario sequence
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rd(`RTC_ADDR_PWR_LOST, 16'h0000, "early read");
    repeat (20) if (sync_ready !== 1'b1) @(negedge clk);
    chk("sync_ready", 16'h0001, {15'h0, sync_ready});
    rd(`RTC_ADDR_PWR_LOST, 16'h0001, "power lost");
    rd(16'h1902, 16'h0000, "unmapped");
    // periodic events with the cpu interrupt still off
    wr(`RTC_ADDR_SRC_EN, 16'h0001);
    repeat (300) if (clk_wake_req !== 1'b1) @(negedge clk);
    rd(`RTC_ADDR_FLAGS, 16'h0001, "ms flag");
    chk("irq gated", 16'h0000, {15'h0, irq});
    for (int i = 2; i < 5; i++)
    begin
      wr(`RTC_ADDR_SRC_EN, 16'h0001 << i);
      wr(`RTC_ADDR_FLAGS, 16'hFFFF);
      @(negedge clk);
      {mi, hi, di} = 3'h7;
      @(negedge clk);
      {mi, hi, di} = 3'h0;
      rd(`RTC_ADDR_FLAGS, 16'h0001 << i, "unit flag");
    end
    // alarm: unloaded, then loaded
    wr(`RTC_ADDR_FLAGS, 16'hFFFF);
    wr(`RTC_ADDR_SRC_EN, 16'h8000);
    wr(`RTC_ADDR_IRQ_EN, 16'h0001);
    arm(48'h4619_0307_0510, 1'b0);
    repeat (400) @(negedge clk);
    chk("unloaded alarm", 16'h0000, {15'h0, irq});
    arm(48'h4619_0307_0510, 1'b1);
    repeat (400) if (irq !== 1'b1) @(negedge clk);
    chk("alarm irq", 16'h0001, {15'h0, irq});
    wr(`RTC_ADDR_FLAGS, 16'h0000);
    rd(`RTC_ADDR_FLAGS, 16'h8000, "flag kept");
    rd(`RTC_ADDR_ALM_SEC, 16'h0046, "alarm readback");
    wr(`RTC_ADDR_FLAGS, 16'h8000);
    chk("irq level", 16'h0000, {15'h0, irq});
    foreach (bad[i])
    begin
      arm(bad[i], 1'b1);
      repeat (400) @(negedge clk);
      rd(`RTC_ADDR_FLAGS, 16'h0000, "out of range");
    end
    // wake pin as output, then as input
    wr(`RTC_ADDR_SRC_EN, 16'h0020);
    wr(`RTC_ADDR_PWR_CTRL, 16'h0004);
    rd(`RTC_ADDR_PWR_CTRL, 16'h0004, "wake dir");
    wake = 1'b1;
    repeat (2) @(negedge clk);
    chk("wake out", 16'h0000, {15'h0, clk_wake_req});
    rd(`RTC_ADDR_FLAGS, 16'h0000, "wake out flag");
    wake = 1'b0;
    wr(`RTC_ADDR_PWR_CTRL, 16'h0000);
    @(negedge clk);
    wake = 1'b1;
    repeat (3) @(negedge clk);
    chk("wake req", 16'h0001, {15'h0, clk_wake_req});
    rd(`RTC_ADDR_FLAGS, 16'h0020, "wake flag");
    chk("wake irq", 16'h0001, {15'h0, irq});
    wr(`RTC_ADDR_FLAGS, 16'hFFFF);
    chk("pin level", 16'h0001, {15'h0, clk_wake_req});
    wake = 1'b0;
    repeat (2) @(negedge clk);
    chk("wake idle", 16'h0000, {15'h0, clk_wake_req});
    // soft reset, then bus kept idle for the sync time
    wr(`RTC_ADDR_OSC, 16'h0020);
    repeat (20) @(negedge clk);
    rd(`RTC_ADDR_PWR_LOST, 16'h0000, "lost cleared");
    rd(`RTC_ADDR_ALM_SEC, 16'h0000, "alarm default");
    rd(`RTC_ADDR_SRC_EN, 16'h0000, "source default");
    rd(`RTC_ADDR_IRQ_EN, 16'h0000, "enable default");
    // millisecond count restarts at zero and steps every 32 rtc clocks
    chk("ms cleared", 16'h0000, {3'h0, ms_value});
    repeat (200) if (ms_value !== 13'h0001) @(negedge clk);
    while (ms_value === 13'h0001 && ms_gap < 200)
    begin
      @(negedge clk);
      ms_gap++;
    end
    chk("ms step", 16'h0002, {3'h0, ms_value});
    chk("ms period", 16'h0080, ms_gap[15:0]);
    chk("sec step", 16'h0000, {15'h0, sec_advance});
    stop_test();
  end
endmodule : testbench
`default_nettype wire
